// file: verilog/adcc_regs.vh
// Register map, field positions, reset values and timing counts for the
// converter control block.
// Assumes byte-wide registers, each on an aligned 32-bit AXI4-Lite word.
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// Byte offsets
`define ADCC_OFF_CTRL0 8'h00
`define ADCC_OFF_SRCCLK 8'h04
`define ADCC_OFF_REFGAIN 8'h08
`define ADCC_OFF_BGAP 8'h0c
`define ADCC_OFF_RES_HI 8'h10
`define ADCC_OFF_RES_LO 8'h14
`define ADCC_OFF_EVENT 8'h18

// Start/channel control fields
`define ADCC_START_BIT 7
`define ADCC_BUSY_BIT 6
`define ADCC_ENABLE_BIT 5
`define ADCC_JUSTIFY_BIT 4
`define ADCC_CHAN_MSB 3
`define ADCC_CHAN_LSB 0

// Source/clock fields
`define ADCC_SRC_MSB 7
`define ADCC_SRC_LSB 4
`define ADCC_CKDIV_MSB 2
`define ADCC_CKDIV_LSB 0

// Reference/gain fields
`define ADCC_AMPEN_BIT 7
`define ADCC_AMPIN_BIT 4
`define ADCC_REF_MSB 3
`define ADCC_REF_LSB 2
`define ADCC_GAIN_MSB 1
`define ADCC_GAIN_LSB 0

// Bandgap and event fields
`define ADCC_BGEN_BIT 0
`define ADCC_EOC_BIT 0

// Reset values
`define ADCC_RST_CTRL0 8'h00
`define ADCC_RST_SRCCLK 8'h00
`define ADCC_RST_REFGAIN 8'h00
`define ADCC_RST_BGAP 8'h00

// Conversion clocks per conversion
`define ADCC_CONV_CLKS 5'h10

// AXI responses
`define ADCC_RESP_OKAY 2'b00
`define ADCC_RESP_SLVERR 2'b10

`endif

// file: verilog/adcc_clkdiv.v
// Conversion clock divider: one-cycle enable pulse at aclk / 2^div.
// Assumes clr is pulsed at the start of each conversion to align phase.
`timescale 1ns/1ps
`default_nettype none

module adcc_clkdiv (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire clr,
  input wire [2:0] div,
  // Enable pulse
  output reg tick
);

  reg [6:0] cnt_r;
  wire [6:0] lim;

  // Terminal count is 2^div - 1; code 000 ticks every cycle
  assign lim = (7'h01 << div) - 7'h01;

  always @(posedge aclk) begin
    if (!aresetn || clr) begin
      cnt_r <= 7'h00;
      tick <= 1'b0;
    end else if (cnt_r >= lim) begin
      cnt_r <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 7'h01;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: verilog/adcc_route.v
// Analog switch decode: channel, internal source and reference routing.
// Outputs are registered so the switch controls never glitch.
`timescale 1ns/1ps
`default_nettype none

module adcc_route (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Selections
  input wire [3:0] external_channel_select,
  input wire [3:0] signal_source_select,
  input wire [1:0] reference_source_select,
  input wire amplifier_input_select,
  // Input switches
  output reg [11:0] ext_chan_on,
  output reg src_supply,
  output reg src_supply_div2,
  output reg src_supply_div4,
  output reg src_amp,
  output reg src_amp_div2,
  output reg src_amp_div4,
  output reg src_ground,
  // Reference switches
  output reg ref_supply,
  output reg ref_ext_pin_on,
  output reg ref_amp,
  output reg amp_ext_ref_pin_on
);

  // External path for 0000, 0100 and 11xx
  function is_ext;
    input [3:0] s;
    begin
      is_ext = (s == 4'h0) || (s == 4'h4) || (s[3:2] == 2'b11);
    end
  endfunction

  wire ext_path = is_ext(signal_source_select);

  genvar i;
  generate
    for (i = 0; i < 12; i = i + 1) begin : g_chan
      // Codes 1100..1111 match no channel and leave the input floating
      always @(posedge aclk) begin
        if (!aresetn)
          ext_chan_on[i] <= 1'b0;
        else
          ext_chan_on[i] <= ext_path && (external_channel_select == i);
      end
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      src_supply <= 1'b0;
      src_supply_div2 <= 1'b0;
      src_supply_div4 <= 1'b0;
      src_amp <= 1'b0;
      src_amp_div2 <= 1'b0;
      src_amp_div4 <= 1'b0;
      src_ground <= 1'b0;
      ref_supply <= 1'b1;
      ref_ext_pin_on <= 1'b0;
      ref_amp <= 1'b0;
      amp_ext_ref_pin_on <= 1'b1;
    end else begin
      src_supply <= (signal_source_select == 4'h1);
      src_supply_div2 <= (signal_source_select == 4'h2);
      src_supply_div4 <= (signal_source_select == 4'h3);
      src_amp <= (signal_source_select == 4'h5);
      src_amp_div2 <= (signal_source_select == 4'h6);
      src_amp_div4 <= (signal_source_select == 4'h7);
      src_ground <= (signal_source_select[3:2] == 2'b10);
      ref_supply <= (reference_source_select == 2'b00);
      ref_ext_pin_on <= (reference_source_select == 2'b01);
      ref_amp <= reference_source_select[1];
      amp_ext_ref_pin_on <= !amplifier_input_select;
    end
  end

endmodule
`default_nettype wire

// file: verilog/adcc_top.v
// Control and configuration registers of a 12-bit converter, on AXI4-Lite.
// Assumes the analog core presents its result on core_result when the
// last conversion clock is reached, and that all inputs share aclk.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_regs.vh"

// Behaviour
// - Start bit high-then-low begins one conversion
// - Busy flag set on start, cleared at end
// - Busy flag readable, writes to it ignored
// - Enable bit powers converter on, off otherwise
// - Results kept unchanged while converter disabled
// - Justify bit selects result byte layout
// - Channel field picks input 0-11, else floating
// - Source field picks external, divided supply, amplifier, ground
// - Source code 0001 routes undivided supply
// - Internal source disconnects the external channel
// - Clock field divides aclk by 1 to 128
// - Amplifier input bit picks pin or bandgap
// - Reference field picks supply, pin or amplifier
// - Gain field sets gain 1, 1.667, 2.5, 3.333
// - Bandgap enable bit switches bandgap on
// - Unimplemented bits read zero, ignore writes
// - End of conversion raises the request flag
// - Unused result bit positions read as zero
module adcc_top (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire awvalid,
  output reg awready,
  input wire [7:0] awaddr,
  input wire [2:0] awprot,
  // AXI4-Lite write data
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address
  input wire arvalid,
  output reg arready,
  input wire [7:0] araddr,
  input wire [2:0] arprot,
  // AXI4-Lite read data
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Converter core
  input wire [11:0] core_result,
  output reg converter_power,
  output reg conv_clk_tick,
  output reg conv_sampling,
  output reg conv_irq_req,
  // Input switches
  output wire [11:0] ext_chan_on,
  output wire src_supply,
  output wire src_supply_div2,
  output wire src_supply_div4,
  output wire src_amp,
  output wire src_amp_div2,
  output wire src_amp_div4,
  output wire src_ground,
  // Reference and amplifier
  output wire ref_supply,
  output wire ref_ext_pin_on,
  output wire ref_amp,
  output wire amp_ext_ref_pin_on,
  output reg amplifier_enable,
  output reg [1:0] amplifier_gain_select,
  output reg bandgap_enable
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  // Software-visible state
  reg start_r;
  reg conv_in_progress_flag_r;
  reg converter_enable_r;
  reg result_justify_select_r;
  reg [3:0] external_channel_select_r;
  reg [3:0] signal_source_select_r;
  reg [2:0] conv_clock_divider_r;
  reg amplifier_input_select_r;
  reg [1:0] reference_source_select_r;
  reg [11:0] result_r;
  reg eoc_flag_r;

  // Conversion sequencer
  reg state_r;
  reg [4:0] clk_cnt_r;
  reg div_clr_r;
  wire div_tick;

  // Bus holding registers
  reg aw_hold_r;
  reg w_hold_r;
  reg [7:0] waddr_r;
  reg [7:0] wbyte_r;
  reg wlane_r;

  // Write and start decode
  wire do_write = aw_hold_r && w_hold_r && !bvalid;
  wire wr_ctrl0 = do_write && wlane_r && (waddr_r == `ADCC_OFF_CTRL0);
  wire start_fall = wr_ctrl0 && start_r && !wbyte_r[`ADCC_START_BIT];
  // A tick already registered when the divider is cleared predates the restart
  wire div_tick_q = div_tick && !div_clr_r;
  wire last_clk = div_tick_q && (clk_cnt_r == `ADCC_CONV_CLKS - 5'h01);

  // Address decode shared by read and write paths
  function addr_ok;
    input [7:0] a;
    begin
      case (a)
        `ADCC_OFF_CTRL0, `ADCC_OFF_SRCCLK, `ADCC_OFF_REFGAIN,
        `ADCC_OFF_BGAP, `ADCC_OFF_RES_HI, `ADCC_OFF_RES_LO,
        `ADCC_OFF_EVENT: addr_ok = 1'b1;
        default: addr_ok = 1'b0;
      endcase
    end
  endfunction

  // Read view of one register; unused bits are zero
  function [7:0] read_reg;
    input [7:0] a;
    begin
      case (a)
        `ADCC_OFF_CTRL0:
          read_reg = {start_r, conv_in_progress_flag_r, converter_enable_r,
                      result_justify_select_r, external_channel_select_r};
        `ADCC_OFF_SRCCLK:
          read_reg = {signal_source_select_r, 1'b0, conv_clock_divider_r};
        `ADCC_OFF_REFGAIN:
          read_reg = {amplifier_enable, 2'b00, amplifier_input_select_r,
                      reference_source_select_r, amplifier_gain_select};
        `ADCC_OFF_BGAP:
          read_reg = {7'h00, bandgap_enable};
        `ADCC_OFF_RES_HI:
          read_reg = result_justify_select_r ? {4'h0, result_r[11:8]}
                                             : result_r[11:4];
        `ADCC_OFF_RES_LO:
          read_reg = result_justify_select_r ? result_r[7:0]
                                             : {result_r[3:0], 4'h0};
        `ADCC_OFF_EVENT:
          read_reg = {7'h00, eoc_flag_r};
        default:
          read_reg = 8'h00;
      endcase
    end
  endfunction

  // Write address and data are taken independently, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      waddr_r <= 8'h00;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `ADCC_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        awready <= 1'b0;
        waddr_r <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wready <= 1'b0;
        wbyte_r <= wdata[7:0];
        wlane_r <= wstrb[0];
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= addr_ok(waddr_r) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
      end
      // Ready stays low until the response is taken: one write at a time
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read answers one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `ADCC_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, read_reg({araddr[7:2], 2'b00})};
      rresp <= addr_ok({araddr[7:2], 2'b00}) ? `ADCC_RESP_OKAY
                                              : `ADCC_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Configuration registers; byte lane 0 carries every field
  always @(posedge aclk) begin
    if (!aresetn) begin
      start_r <= 1'b0;
      converter_enable_r <= 1'b0;
      result_justify_select_r <= 1'b0;
      external_channel_select_r <= 4'h0;
      signal_source_select_r <= 4'h0;
      conv_clock_divider_r <= 3'h0;
      amplifier_enable <= 1'b0;
      amplifier_input_select_r <= 1'b0;
      reference_source_select_r <= 2'b00;
      amplifier_gain_select <= 2'b00;
      bandgap_enable <= 1'b0;
    end else if (do_write && wlane_r) begin
      case (waddr_r)
        `ADCC_OFF_CTRL0: begin
          // Busy bit position is not stored from the bus
          start_r <= wbyte_r[`ADCC_START_BIT];
          converter_enable_r <= wbyte_r[`ADCC_ENABLE_BIT];
          result_justify_select_r <= wbyte_r[`ADCC_JUSTIFY_BIT];
          external_channel_select_r <= wbyte_r[`ADCC_CHAN_MSB:`ADCC_CHAN_LSB];
        end
        `ADCC_OFF_SRCCLK: begin
          signal_source_select_r <= wbyte_r[`ADCC_SRC_MSB:`ADCC_SRC_LSB];
          conv_clock_divider_r <= wbyte_r[`ADCC_CKDIV_MSB:`ADCC_CKDIV_LSB];
        end
        `ADCC_OFF_REFGAIN: begin
          amplifier_enable <= wbyte_r[`ADCC_AMPEN_BIT];
          amplifier_input_select_r <= wbyte_r[`ADCC_AMPIN_BIT];
          reference_source_select_r <= wbyte_r[`ADCC_REF_MSB:`ADCC_REF_LSB];
          amplifier_gain_select <= wbyte_r[`ADCC_GAIN_MSB:`ADCC_GAIN_LSB];
        end
        `ADCC_OFF_BGAP:
          bandgap_enable <= wbyte_r[`ADCC_BGEN_BIT];
        default: begin
          // Result and unmapped addresses are not writable
        end
      endcase
    end
  end

  // Conversion sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      conv_in_progress_flag_r <= 1'b0;
      clk_cnt_r <= 5'h00;
      div_clr_r <= 1'b1;
      result_r <= 12'h000;
    end else begin
      div_clr_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // A start while disabled is dropped rather than queued
          if (start_fall && converter_enable_r) begin
            state_r <= ST_CONV;
            conv_in_progress_flag_r <= 1'b1;
            clk_cnt_r <= 5'h00;
            div_clr_r <= 1'b1;
          end
        end
        ST_CONV: begin
          if (!converter_enable_r) begin
            // Power-down aborts; the old result stays put
            state_r <= ST_IDLE;
            conv_in_progress_flag_r <= 1'b0;
          end else if (last_clk) begin
            state_r <= ST_IDLE;
            conv_in_progress_flag_r <= 1'b0;
            result_r <= core_result;
          end else if (div_tick_q) begin
            clk_cnt_r <= clk_cnt_r + 5'h01;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          conv_in_progress_flag_r <= 1'b0;
        end
      endcase
    end
  end

  // End-of-conversion request flag; a new end wins over a clear
  always @(posedge aclk) begin
    if (!aresetn)
      eoc_flag_r <= 1'b0;
    else if (state_r == ST_CONV && converter_enable_r && last_clk)
      eoc_flag_r <= 1'b1;
    else if (do_write && wlane_r && waddr_r == `ADCC_OFF_EVENT &&
             wbyte_r[`ADCC_EOC_BIT])
      eoc_flag_r <= 1'b0;
  end

  // Registered core controls
  always @(posedge aclk) begin
    if (!aresetn) begin
      converter_power <= 1'b0;
      conv_clk_tick <= 1'b0;
      conv_sampling <= 1'b0;
      conv_irq_req <= 1'b0;
    end else begin
      converter_power <= converter_enable_r;
      conv_clk_tick <= div_tick_q && (state_r == ST_CONV);
      conv_sampling <= (state_r == ST_CONV);
      conv_irq_req <= eoc_flag_r;
    end
  end

  adcc_clkdiv u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(div_clr_r),
    .div(conv_clock_divider_r),
    .tick(div_tick)
  );

  adcc_route u_route (
    .aclk(aclk),
    .aresetn(aresetn),
    .external_channel_select(external_channel_select_r),
    .signal_source_select(signal_source_select_r),
    .reference_source_select(reference_source_select_r),
    .amplifier_input_select(amplifier_input_select_r),
    .ext_chan_on(ext_chan_on),
    .src_supply(src_supply),
    .src_supply_div2(src_supply_div2),
    .src_supply_div4(src_supply_div4),
    .src_amp(src_amp),
    .src_amp_div2(src_amp_div2),
    .src_amp_div4(src_amp_div4),
    .src_ground(src_ground),
    .ref_supply(ref_supply),
    .ref_ext_pin_on(ref_ext_pin_on),
    .ref_amp(ref_amp),
    .amp_ext_ref_pin_on(amp_ext_ref_pin_on)
  );

endmodule
`default_nettype wire

// file: sim/adcc_core_model.sv
// Behavioural model of the analog core behind the converter control block.
// Assumes the bench sets val before a start; outside conversions the
// output toggles every cycle so a stray sample never looks like a result.
`timescale 1ns/1ps
`default_nettype none

module adcc_core_model (
  // Clock
  input wire logic aclk,
  // Core control
  input wire logic conv_sampling,
  input wire logic [11:0] val,
  // Result
  output logic [11:0] core_result
);
  initial core_result = 12'h000;
  always @(posedge aclk) begin
    if (conv_sampling) begin
      core_result <= val;
    end else begin
      core_result <= ~core_result;
    end
  end
endmodule

`default_nettype wire

// file: sim/adcc_asserts.sv
// Concurrent checks on the ports of the converter control block.
// Assumes it is bound into adcc_top, which has a single clock domain.
`timescale 1ns/1ps
`default_nettype none

module adcc_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus answers
  input wire logic arvalid, arready, rvalid, rready, bvalid, bready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] bresp,
  // Converter
  input wire logic conv_clk_tick, conv_sampling, conv_irq_req, converter_power,
  // Switches
  input wire logic [11:0] ext_chan_on,
  input wire logic src_supply, src_supply_div2, src_supply_div4, src_amp,
  input wire logic src_amp_div2, src_amp_div4, src_ground,
  input wire logic ref_supply, ref_ext_pin_on, ref_amp
);
  logic [5:0] tick_cnt_r;
  wire logic [6:0] src_w = {src_supply, src_supply_div2, src_supply_div4,
    src_amp, src_amp_div2, src_amp_div4, src_ground};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Restarts with each conversion so an extra tick cannot hide
  always @(posedge aclk) begin
    if (!aresetn || !conv_sampling) begin
      tick_cnt_r <= 6'h00;
    end else if (conv_clk_tick) begin
      tick_cnt_r <= tick_cnt_r + 6'h01;
    end
  end
  sequence s_ar_take;
    arvalid && arready;
  endsequence
  sequence s_r_wait;
    rvalid && !rready;
  endsequence
  a_read_answer: assert property (s_ar_take |=> rvalid)
    else $error("read not answered one cycle after address");
  a_rdata_hold: assert property (s_r_wait |=> rvalid && $stable(rdata))
    else $error("read data dropped before rready");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  a_int_src_isol: assert property (|src_w |-> ext_chan_on == 12'h000)
    else $error("external channel connected with internal source");
  a_chan_onehot: assert property ($onehot0(ext_chan_on))
    else $error("more than one external channel connected");
  a_src_onehot: assert property ($onehot0(src_w))
    else $error("more than one internal source connected");
  a_ref_onehot: assert property ($onehot({ref_supply, ref_ext_pin_on, ref_amp}))
    else $error("reference selection not exactly one source");
  a_tick_gated: assert property (conv_clk_tick |-> conv_sampling)
    else $error("conversion clock tick outside conversion");
  a_tick_count: assert property (tick_cnt_r <= 6'd16)
    else $error("more than sixteen ticks in one conversion");
  a_irq_after_conv: assert property ($rose(conv_irq_req) |-> $past(conv_sampling, 2))
    else $error("request flag raised without a conversion");
  a_power_abort: assert property ($fell(converter_power) |-> ##[0:2] !conv_sampling)
    else $error("conversion kept running after power down");
  c_conv_end: cover property ($fell(conv_sampling));
endmodule

bind adcc_top adcc_asserts u_chk (.aclk, .aresetn, .arvalid, .arready, .rvalid,
  .rready, .bvalid, .bready, .rdata, .bresp, .conv_clk_tick, .conv_sampling,
  .conv_irq_req, .converter_power, .ext_chan_on, .src_supply, .src_supply_div2,
  .src_supply_div4, .src_amp, .src_amp_div2, .src_amp_div4, .src_ground,
  .ref_supply, .ref_ext_pin_on, .ref_amp);

`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the converter control block over AXI4-Lite.
// Assumes adcc_top with the behavioural analog core model at core_result.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr, hi;
  logic [31:0] wdata, d;
  logic [11:0] val;
  logic [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid, converter_power, conv_clk_tick;
  wire conv_sampling, conv_irq_req, src_supply, src_supply_div2, src_supply_div4;
  wire src_amp, src_amp_div2, src_amp_div4, src_ground, ref_supply, ref_ext_pin_on;
  wire ref_amp, amp_ext_ref_pin_on, amplifier_enable, bandgap_enable;
  wire [1:0] bresp, rresp, amplifier_gain_select;
  wire [31:0] rdata;
  wire [11:0] core_result, ext_chan_on;
  integer err_count, samples_checked, ticks, cyc, i, n, k, t0, c0;

  adcc_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb(4'h1), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .core_result, .converter_power, .conv_clk_tick, .conv_sampling, .conv_irq_req,
    .ext_chan_on, .src_supply, .src_supply_div2, .src_supply_div4, .src_amp,
    .src_amp_div2, .src_amp_div4, .src_ground, .ref_supply, .ref_ext_pin_on,
    .ref_amp, .amp_ext_ref_pin_on, .amplifier_enable, .amplifier_gain_select,
    .bandgap_enable);
  adcc_core_model core (.aclk, .conv_sampling, .val, .core_result);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Running totals; scenarios compare differences
  always @(posedge aclk) begin
    if (conv_clk_tick === 1'b1) ticks <= ticks + 1;
    if (conv_sampling === 1'b1) cyc <= cyc + 1;
  end

  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      err_count++;
    end
  endtask
  task tmo;
    if (n >= 300) begin
      err_count++;
      conclude;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    // Ready is raised only once the answer shows, so the slave must hold it
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && !bready) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready) && n < 300);
    r = bresp;
    bready <= 1'b0;
    tmo;
  endtask
  task w(input logic [7:0] a, input logic [7:0] v);
    wr(a, v, rs);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && !rready) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready) && n < 300);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    tmo;
  endtask
  // Switch pattern {supply, /2, /4, amp, amp/2, amp/4, ground}
  function automatic logic [6:0] src_exp(input logic [3:0] c);
    case (c)
      4'h1: src_exp = 7'h40;
      4'h2: src_exp = 7'h20;
      4'h3: src_exp = 7'h10;
      4'h5: src_exp = 7'h08;
      4'h6: src_exp = 7'h04;
      4'h7: src_exp = 7'h02;
      4'h8, 4'h9, 4'ha, 4'hb: src_exp = 7'h01;
      default: src_exp = 7'h00;
    endcase
  endfunction

  initial begin
    {err_count, samples_checked, ticks, cyc} = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, val} = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 16; i += 4) begin
      rd(i[7:0], d);
      chk(d, 0);
    end
    w(8'h04, 8'hff);
    rd(8'h04, d);
    chk(d, 32'hf7);
    w(8'h08, 8'hff);
    rd(8'h08, d);
    chk(d, 32'h9f);
    w(8'h0c, 8'hff);
    rd(8'h0c, d);
    chk(d, 32'h01);
    chk(bandgap_enable, 1);
    w(8'h00, 8'h40);
    rd(8'h00, d);
    chk(d, 0);
    rd(8'h1c, d);
    chk(rs, 2'b10);
    chk(d, 0);
    wr(8'h1c, 8'h5a, rs);
    chk(rs, 2'b10);
    w(8'h00, 8'h23);
    for (i = 0; i < 16; i++) begin
      w(8'h04, {i[3:0], 4'h0});
      repeat (3) @(posedge aclk);
      chk({src_supply, src_supply_div2, src_supply_div4, src_amp, src_amp_div2,
        src_amp_div4, src_ground}, src_exp(i[3:0]));
      chk(ext_chan_on, (i == 0 || i == 4 || i > 11) ? 12'h008 : 12'h000);
    end
    w(8'h04, 8'h00);
    w(8'h00, 8'h2c);
    repeat (3) @(posedge aclk);
    chk(ext_chan_on, 0);
    for (i = 0; i < 8; i++) begin
      w(8'h08, {1'b1, 2'b00, i[0], i[2:1], i[1:0]});
      repeat (3) @(posedge aclk);
      chk({ref_supply, ref_ext_pin_on, ref_amp, amp_ext_ref_pin_on},
        {i[2:1] == 0, i[2:1] == 1, i[2], !i[0]});
      chk({amplifier_enable, amplifier_gain_select}, {1'b1, i[1:0]});
    end
    // Every divider code, alternating justification
    for (i = 0; i < 8; i++) begin
      val = 12'ha5c ^ {i[2:0], i[2:0], i[2:0], i[2:0]};
      w(8'h04, {5'h00, i[2:0]});
      w(8'h00, {3'b001, i[0], 4'h0});
      w(8'h00, {3'b101, i[0], 4'h0});
      t0 = ticks;
      c0 = cyc;
      w(8'h00, {3'b001, i[0], 4'h0});
      rd(8'h00, d);
      chk(d[6], 1);
      k = 0;
      while (d[6] !== 1'b0 && k < 2000) begin
        rd(8'h00, d);
        k++;
      end
      if (k >= 2000) begin
        err_count++;
        conclude;
      end
      chk(ticks - t0, 16);
      chk((cyc - c0) >= (16 << i) && (cyc - c0) <= (17 << i) + 2, 1);
      rd(8'h10, d);
      chk(d, i[0] ? {4'h0, val[11:8]} : val[11:4]);
      rd(8'h14, d);
      chk(d, i[0] ? val[7:0] : {val[3:0], 4'h0});
      chk(conv_irq_req, 1);
      rd(8'h18, d);
      chk(d, 1);
      w(8'h18, 8'h01);
      rd(8'h18, d);
      chk(d, 0);
    end
    hi = {4'h0, val[11:8]};
    val = ~val;
    // Start while disabled must be ignored
    w(8'h00, 8'h10);
    w(8'h00, 8'h90);
    w(8'h00, 8'h10);
    rd(8'h00, d);
    chk(d, 32'h10);
    chk(converter_power, 0);
    rd(8'h10, d);
    chk(d, hi);
    // Abort a slow conversion by clearing the enable
    w(8'h00, 8'h30);
    w(8'h00, 8'hb0);
    w(8'h00, 8'h30);
    rd(8'h00, d);
    chk(d, 32'h70);
    chk(converter_power, 1);
    w(8'h00, 8'h10);
    repeat (3) @(posedge aclk);
    rd(8'h00, d);
    chk(d, 32'h10);
    rd(8'h10, d);
    chk(d, hi);
    rd(8'h18, d);
    chk(d, 0);
    conclude;
  end
endmodule

`default_nettype wire
